/* File: csw_pkg.sv */
// Purpose: shared constants and types of the compare-swap and rom header register bank
// Assumes: one clock, synchronous active-high reset
// Notes: offsets are byte addresses on a 32-bit register port
package csw_pkg;

  localparam int unsigned CSW_DATA_W = 32;
  localparam int unsigned CSW_ADDR_W = 8;
  localparam int unsigned CSW_SEL_W = 2;
  localparam int unsigned CSW_CRC_W = 16;
  localparam int unsigned CSW_IRQ_W = 2;

  // documented register offsets
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_NEW_VALUE = 8'h0c;
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_COMPARE = 8'h10;
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_CONTROL = 8'h14;
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_ROM_HEADER = 8'h18;
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_BUS_ID = 8'h1c;
  // loading ports, status and interrupt registers
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_IRQ_STATUS = 8'h30;
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_IRQ_CLEAR = 8'h34;
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_IRQ_ENABLE = 8'h38;
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_ROM_STATUS = 8'h3c;
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_LOAD_NEW = 8'h40;
  localparam logic [CSW_ADDR_W-1:0] CSW_OFS_LOAD_COMPARE = 8'h44;

  // field positions
  localparam int unsigned CSW_DONE_BIT = 31;
  localparam int unsigned CSW_PRESENT_BIT = 24;
  localparam int unsigned CSW_IRQ_SWAP_BIT = 0;
  localparam int unsigned CSW_IRQ_ROM_BIT = 1;

  // reset and constant values
  localparam logic [CSW_DATA_W-1:0] CSW_BUS_ID_VALUE = 32'h31333934;
  localparam logic [CSW_DATA_W-1:0] CSW_ROM_HEADER_RESET = 32'h00000000;
  localparam logic [CSW_DATA_W-1:0] CSW_ZERO = 32'h00000000;
  localparam logic [CSW_IRQ_W-1:0] CSW_IRQ_RESET = 2'h0;

  typedef enum logic [CSW_SEL_W-1:0] {
    CSW_RES_BUS_MANAGER_ID = 2'b00,
    CSW_RES_BANDWIDTH_AVAILABLE = 2'b01,
    CSW_RES_CHANNELS_AVAILABLE_HI = 2'b10,
    CSW_RES_CHANNELS_AVAILABLE_LO = 2'b11
  } csw_resource_type;

  typedef enum logic {
    CSW_ST_IDLE = 1'b0,
    CSW_ST_CHECK = 1'b1
  } csw_state_type;

  typedef struct packed {
    logic [CSW_ADDR_W-1:0] addr;
    logic [CSW_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } csw_bus_req_type;

endpackage

/* File: csw_resource_mem.sv */
// Purpose: storage of the four bus-management resources
// Assumes: one clock, synchronous active-high reset, clock enable freezes all state
// Notes: read data come out of a register one cycle after the read request
`timescale 1ns/1ps
module csw_resource_mem
  import csw_pkg::*;
#(
  parameter int unsigned WIDTH = CSW_DATA_W,
  parameter int unsigned AW = CSW_SEL_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data
);

  if (WIDTH < 1 || AW < 1) begin : g_check
    $error("csw_resource_mem: width and address width must be at least one");
  end

  logic [WIDTH-1:0] mem [2**AW];

  // contents are left alone by reset, as the resources have no defined start value
  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data <= '0;
    end else if (clk_en && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

/* File: csw_register_bank.sv */
// Purpose: host registers for compare-swap on bus-management resources and rom header quadlets
// Assumes: one clock, synchronous active-high reset, strobes one cycle long
// Notes: read data stand for one cycle after the read strobe, zero otherwise
//
// How it works
// - The swap new-value register holds the value stored into the chosen resource on a match.
// - The compare register holds the value checked against the chosen resource's contents.
// - Both of those registers are read-only at their own offsets and loaded through the load offsets, all 32 bits readable.
// - The completion flag in bit 31 of the swap control register sets when a swap finishes.
// - A write to the swap control register clears the completion flag, whatever bit 31 is, except in a swap's check cycle.
// - The two low bits of swap control pick bus manager id, bandwidth, or channels hi/lo.
// - Bits 30 to 2 of the swap control register read as zero.
// - The rom header register is offered to remote nodes as the first rom quadlet.
// - The header crc field is loaded from the serial rom when one is present.
// - The bus identification register is read-only and always returns the ascii of 1394.
// - The bus identification value is offered to remote nodes as the first bus info quadlet.
// - A read-only flag tells whether a serial rom is present; if so a load is asked once after reset release.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module csw_register_bank
  import csw_pkg::*;
#(
  parameter int unsigned ADDR_W = CSW_ADDR_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire csw_bus_req_type bus_req,
  output logic [CSW_DATA_W-1:0] rd_data,
  // serial rom reader side
  input wire logic serial_rom_present,
  input wire logic rom_crc_valid,
  input wire logic [CSW_CRC_W-1:0] rom_crc_value,
  output logic rom_load_request,
  // quadlets seen by remote nodes
  output logic [CSW_DATA_W-1:0] rom_header_quadlet,
  output logic [CSW_DATA_W-1:0] bus_id_quadlet,
  // interrupt
  output logic irq
);

  if (ADDR_W != CSW_ADDR_W) begin : g_check
    $error("csw_register_bank: address width must match the register map");
  end

  function automatic logic hit(input logic [CSW_ADDR_W-1:0] a,
                               input logic [CSW_ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // the resource select sits in the low bits of a control write
  function automatic csw_resource_type sel_field(input logic [CSW_DATA_W-1:0] d);
    return csw_resource_type'(d[CSW_SEL_W-1:0]);
  endfunction

  logic wr_control;
  logic wr_header;
  logic wr_clear;
  logic wr_enable;
  logic wr_load_new;
  logic wr_load_cmp;

  assign wr_control = bus_req.wr && hit(bus_req.addr, CSW_OFS_CONTROL);
  assign wr_header = bus_req.wr && hit(bus_req.addr, CSW_OFS_ROM_HEADER);
  assign wr_clear = bus_req.wr && hit(bus_req.addr, CSW_OFS_IRQ_CLEAR);
  assign wr_enable = bus_req.wr && hit(bus_req.addr, CSW_OFS_IRQ_ENABLE);
  assign wr_load_new = bus_req.wr && hit(bus_req.addr, CSW_OFS_LOAD_NEW);
  assign wr_load_cmp = bus_req.wr && hit(bus_req.addr, CSW_OFS_LOAD_COMPARE);

  // swap operand registers; no reset, their contents start undefined
  logic [CSW_DATA_W-1:0] new_value_reg;
  logic [CSW_DATA_W-1:0] compare_value_reg;

  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_load_new) begin
      new_value_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_load_cmp) begin
      compare_value_reg <= bus_req.wdata;
    end
  end

  // swap sequencer
  csw_state_type state_reg;
  csw_state_type state_next;
  csw_resource_type select_reg;
  logic swap_complete_flag_reg;
  logic swap_complete_flag_next;
  logic start;
  logic finish;
  logic match;
  logic [CSW_DATA_W-1:0] res_rdata;

  // a write while a swap is still checking is not started again
  assign start = wr_control && (state_reg == CSW_ST_IDLE);
  assign finish = state_reg == CSW_ST_CHECK;
  assign match = finish && (res_rdata == compare_value_reg);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CSW_ST_IDLE: begin
        if (start) begin
          state_next = CSW_ST_CHECK;
        end
      end
      CSW_ST_CHECK: begin
        state_next = CSW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= CSW_ST_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // select may only change at a start, so the check uses the resource that was read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      select_reg <= CSW_RES_BUS_MANAGER_ID;
    end else if (clk_en && start) begin
      select_reg <= sel_field(bus_req.wdata);
    end
  end

  // completion wins over a clearing write in the same cycle
  always_comb begin
    swap_complete_flag_next = swap_complete_flag_reg;
    if (finish) begin
      swap_complete_flag_next = 1'b1;
    end else if (wr_control) begin
      swap_complete_flag_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      swap_complete_flag_reg <= 1'b1;
    end else if (clk_en) begin
      swap_complete_flag_reg <= swap_complete_flag_next;
    end
  end

  // the resource is read at the start and written back on a match one cycle later
  csw_resource_mem #(
    .WIDTH(CSW_DATA_W),
    .AW(CSW_SEL_W)
  ) u_resources (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .rd_en(start),
    .rd_addr(sel_field(bus_req.wdata)),
    .rd_data(res_rdata),
    .wr_en(match),
    .wr_addr(select_reg),
    .wr_data(new_value_reg)
  );

  // serial rom presence is a strap caught once after reset release
  logic strap_taken_reg;
  logic serial_rom_present_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strap_taken_reg <= 1'b0;
    end else if (clk_en) begin
      strap_taken_reg <= 1'b1;
    end
  end

  // later changes of the strap are ignored until the next reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      serial_rom_present_reg <= 1'b0;
    end else if (clk_en && !strap_taken_reg) begin
      serial_rom_present_reg <= serial_rom_present;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rom_load_request <= 1'b0;
    end else if (clk_en) begin
      rom_load_request <= serial_rom_present && !strap_taken_reg;
    end
  end

  // rom header; a host write beats a crc load arriving in the same cycle
  logic [CSW_DATA_W-1:0] rom_header_reg;
  logic rom_load;

  assign rom_load = rom_crc_valid && serial_rom_present_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rom_header_reg <= CSW_ROM_HEADER_RESET;
    end else if (clk_en) begin
      if (wr_header) begin
        rom_header_reg <= bus_req.wdata;
      end else if (rom_load) begin
        rom_header_reg[CSW_CRC_W-1:0] <= rom_crc_value;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rom_header_quadlet <= CSW_ROM_HEADER_RESET;
    end else if (clk_en) begin
      rom_header_quadlet <= rom_header_reg;
    end
  end

  // a register of a constant, kept so that the output still comes from a flip-flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_id_quadlet <= CSW_BUS_ID_VALUE;
    end else if (clk_en) begin
      bus_id_quadlet <= CSW_BUS_ID_VALUE;
    end
  end

  // interrupt status, enable and clear
  logic [CSW_IRQ_W-1:0] irq_status_reg;
  logic [CSW_IRQ_W-1:0] irq_enable_reg;
  logic [CSW_IRQ_W-1:0] irq_events;

  always_comb begin
    irq_events = CSW_IRQ_RESET;
    irq_events[CSW_IRQ_SWAP_BIT] = finish;
    irq_events[CSW_IRQ_ROM_BIT] = rom_load;
  end

  // an event wins over a clear of the same bit in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_status_reg <= CSW_IRQ_RESET;
    end else if (clk_en) begin
      if (wr_clear) begin
        irq_status_reg <= (irq_status_reg & ~bus_req.wdata[CSW_IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status_reg <= irq_status_reg | irq_events;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_enable_reg <= CSW_IRQ_RESET;
    end else if (clk_en && wr_enable) begin
      irq_enable_reg <= bus_req.wdata[CSW_IRQ_W-1:0];
    end
  end

  // one cycle behind the status bits, the price of a registered output
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // read decode
  // reads have no side effects, so a control read never touches the flag
  logic [CSW_DATA_W-1:0] read_value;

  always_comb begin
    read_value = CSW_ZERO;
    unique case (bus_req.addr)
      CSW_OFS_NEW_VALUE: read_value = new_value_reg;
      CSW_OFS_COMPARE: read_value = compare_value_reg;
      CSW_OFS_CONTROL: begin
        read_value[CSW_DONE_BIT] = swap_complete_flag_reg;
        read_value[CSW_SEL_W-1:0] = select_reg;
      end
      CSW_OFS_ROM_HEADER: read_value = rom_header_reg;
      CSW_OFS_BUS_ID: read_value = CSW_BUS_ID_VALUE;
      CSW_OFS_IRQ_STATUS: read_value[CSW_IRQ_W-1:0] = irq_status_reg;
      CSW_OFS_IRQ_ENABLE: read_value[CSW_IRQ_W-1:0] = irq_enable_reg;
      CSW_OFS_ROM_STATUS: read_value[CSW_PRESENT_BIT] = serial_rom_present_reg;
      default: read_value = CSW_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data <= CSW_ZERO;
    end else if (clk_en) begin
      rd_data <= bus_req.rd ? read_value : CSW_ZERO;
    end
  end

endmodule

/* File: csw_register_bank_chk.sv */
// Purpose: port-level checks of the compare-swap register bank
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every bank instance
`timescale 1ns/1ps
module csw_register_bank_chk
  import csw_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire csw_bus_req_type bus_req,
  input wire logic [CSW_DATA_W-1:0] rd_data,
  // rom side
  input wire logic rom_crc_valid,
  input wire logic rom_load_request,
  input wire logic [CSW_DATA_W-1:0] rom_header_quadlet,
  input wire logic [CSW_DATA_W-1:0] bus_id_quadlet
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic ctrl_wr;
  logic ctrl_rd;
  logic hdr_wr;
  assign ctrl_wr = clk_en && bus_req.wr && bus_req.addr == CSW_OFS_CONTROL;
  assign ctrl_rd = clk_en && bus_req.rd && bus_req.addr == CSW_OFS_CONTROL;
  assign hdr_wr = clk_en && bus_req.wr && bus_req.addr == CSW_OFS_ROM_HEADER;
  // a write in the check cycle of an earlier swap is swallowed, so skip it
  sequence s_start;
    ctrl_wr && !$past(ctrl_wr);
  endsequence
  sequence s_settled;
    clk_en && !ctrl_wr;
  endsequence
  chk_id_const: assert property (bus_id_quadlet == CSW_BUS_ID_VALUE)
    else $error("bus id quadlet not constant");
  chk_rd_idle: assert property (clk_en && !bus_req.rd |=> rd_data == CSW_ZERO)
    else $error("read data not zero outside read");
  chk_id_read: assert property (clk_en && bus_req.rd && bus_req.addr == CSW_OFS_BUS_ID
    |=> rd_data == CSW_BUS_ID_VALUE) else $error("bus id read wrong");
  chk_ctrl_rsvd: assert property (ctrl_rd |=> rd_data[30:2] == 29'h0)
    else $error("control reserved bits set");
  chk_done_clear: assert property (s_start ##1 ctrl_rd |=> !rd_data[CSW_DONE_BIT])
    else $error("done flag not cleared by write");
  chk_done_set: assert property (s_start ##1 s_settled ##1 ctrl_rd
    |=> rd_data[CSW_DONE_BIT]) else $error("done flag not set after swap");
  chk_sel_back: assert property (s_start ##1 ctrl_rd
    |=> rd_data[1:0] == $past(bus_req.wdata[1:0], 2)) else $error("select lost");
  chk_load_pulse: assert property (rom_load_request |=> !rom_load_request)
    else $error("load request longer than one cycle");
  chk_hdr_export: assert property (hdr_wr ##1 (clk_en && !hdr_wr && !rom_crc_valid)
    |=> rom_header_quadlet == $past(bus_req.wdata, 2)) else $error("header not exported");
endmodule

bind csw_register_bank csw_register_bank_chk i_chk (.sys_clk(sys_clk), .reset(reset),
  .clk_en(clk_en), .bus_req(bus_req), .rd_data(rd_data), .rom_crc_valid(rom_crc_valid),
  .rom_load_request(rom_load_request), .rom_header_quadlet(rom_header_quadlet),
  .bus_id_quadlet(bus_id_quadlet));

/* File: csw_register_bank_tb.sv */
// Purpose: self-checking bench of the compare-swap register bank
// Assumes: 40 MHz clock, clk_en held high except in the freeze test
// Notes: resource contents are not visible, so only flags and registers are judged
`timescale 1ns/1ps
module csw_register_bank_tb
  import csw_pkg::*;
;
  logic sys_clk;
  logic reset;
  logic clk_en;
  csw_bus_req_type bus_req;
  logic [CSW_DATA_W-1:0] rd_data;
  logic serial_rom_present;
  logic rom_crc_valid;
  logic [CSW_CRC_W-1:0] rom_crc_value;
  logic rom_load_request;
  logic [CSW_DATA_W-1:0] rom_header_quadlet;
  logic [CSW_DATA_W-1:0] bus_id_quadlet;
  logic irq;
  logic [CSW_DATA_W-1:0] got;
  logic [CSW_DATA_W-1:0] got2;
  int bad_count;
  int checks;
  int load_seen;
  csw_register_bank i_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .bus_req(bus_req), .rd_data(rd_data), .serial_rom_present(serial_rom_present),
    .rom_crc_valid(rom_crc_valid), .rom_crc_value(rom_crc_value),
    .rom_load_request(rom_load_request), .rom_header_quadlet(rom_header_quadlet),
    .bus_id_quadlet(bus_id_quadlet), .irq(irq));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic seen);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  // control write followed at once by two control reads, in the check cycle and just after
  task automatic wr_rd_ctrl(input logic [31:0] d, output logic [31:0] q,
                            output logic [31:0] q2);
    wr_reg(CSW_OFS_CONTROL, d);
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    #1 q = rd_data;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 q2 = rd_data;
  endtask
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 8) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk1("irq", e, irq);
    if (irq !== e) close_out();
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (rom_load_request === 1'b1) load_seen++;
  end
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    bus_req = '0;
    serial_rom_present = 1'b1;
    rom_crc_valid = 1'b0;
    rom_crc_value = 16'h0000;
    bad_count = 0;
    checks = 0;
    load_seen = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    rd_reg(CSW_OFS_CONTROL, got);
    chk32("control reset", 32'h80000000, got);
    wr_reg(CSW_OFS_BUS_ID, 32'h00000000);
    rd_reg(CSW_OFS_BUS_ID, got);
    chk32("bus id", CSW_BUS_ID_VALUE, got);
    chk32("bus id quadlet", CSW_BUS_ID_VALUE, bus_id_quadlet);
    rd_reg(CSW_OFS_ROM_STATUS, got);
    chk1("rom present", 1'b1, got[CSW_PRESENT_BIT]);
    chk32("load requests", 32'h1, 32'(load_seen));
    rd_reg(8'h50, got);
    chk32("unmapped", CSW_ZERO, got);
    $display("test reset values done");
    wr_reg(CSW_OFS_IRQ_ENABLE, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr_reg(CSW_OFS_LOAD_NEW, 32'ha5a50000 | 32'(s));
      wr_reg(CSW_OFS_LOAD_COMPARE, 32'h5a5a0000 | 32'(s));
      wr_reg(CSW_OFS_NEW_VALUE, 32'hffffffff);
      // bit 31 alternates, the flag must clear either way
      wr_rd_ctrl({s[0], 29'h1fffffff, s[1:0]}, got, got2);
      chk32("control busy", {30'h0, s[1:0]}, got);
      chk32("control done early", {1'b1, 29'h0, s[1:0]}, got2);
      wait_irq(1'b1);
      rd_reg(CSW_OFS_CONTROL, got);
      chk32("control done", {1'b1, 29'h0, s[1:0]}, got);
      rd_reg(CSW_OFS_NEW_VALUE, got);
      chk32("new value", 32'ha5a50000 | 32'(s), got);
      rd_reg(CSW_OFS_COMPARE, got);
      chk32("compare value", 32'h5a5a0000 | 32'(s), got);
      wr_reg(CSW_OFS_IRQ_CLEAR, 32'h1);
      wait_irq(1'b0);
    end
    $display("test swap selects done");
    wr_reg(CSW_OFS_IRQ_ENABLE, 32'h0);
    wr_rd_ctrl(32'h00000001, got, got2);
    chk32("control after masked swap", 32'h80000001, got2);
    repeat (4) @(posedge sys_clk);
    chk1("irq masked", 1'b0, irq);
    rd_reg(CSW_OFS_IRQ_STATUS, got);
    chk1("swap status", 1'b1, got[CSW_IRQ_SWAP_BIT]);
    $display("test masked interrupt done");
    wr_reg(CSW_OFS_ROM_HEADER, 32'h0404abcd);
    rd_reg(CSW_OFS_ROM_HEADER, got);
    chk32("header", 32'h0404abcd, got);
    chk32("header quadlet", 32'h0404abcd, rom_header_quadlet);
    @(posedge sys_clk);
    rom_crc_value <= 16'h5a5a;
    rom_crc_valid <= 1'b1;
    @(posedge sys_clk);
    rom_crc_valid <= 1'b0;
    rd_reg(CSW_OFS_ROM_HEADER, got);
    chk32("header crc", 32'h04045a5a, got);
    rd_reg(CSW_OFS_IRQ_STATUS, got);
    chk1("crc status", 1'b1, got[CSW_IRQ_ROM_BIT]);
    $display("test rom header done");
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr_reg(CSW_OFS_ROM_HEADER, 32'h11112222);
    clk_en <= 1'b1;
    rd_reg(CSW_OFS_ROM_HEADER, got);
    chk32("header frozen", 32'h04045a5a, got);
    $display("test clock enable done");
    @(posedge sys_clk);
    serial_rom_present <= 1'b0;
    reset <= 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    rd_reg(CSW_OFS_ROM_STATUS, got);
    chk1("rom absent", 1'b0, got[CSW_PRESENT_BIT]);
    chk32("load requests again", 32'h1, 32'(load_seen));
    rd_reg(CSW_OFS_CONTROL, got);
    chk32("control rereset", 32'h80000000, got);
    @(posedge sys_clk);
    rom_crc_value <= 16'h1234;
    rom_crc_valid <= 1'b1;
    @(posedge sys_clk);
    rom_crc_valid <= 1'b0;
    rd_reg(CSW_OFS_ROM_HEADER, got);
    chk32("header no rom", CSW_ROM_HEADER_RESET, got);
    rd_reg(CSW_OFS_IRQ_STATUS, got);
    chk1("crc status no rom", 1'b0, got[CSW_IRQ_ROM_BIT]);
    $display("test reset without rom done");
    close_out();
  end
endmodule
